// ===== src/ext_mem_pkg.sv
package ext_mem_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  // ---------------------------------------------------------------
  // port d line positions and reset values
  // ---------------------------------------------------------------
  localparam int PORT_D_LINE_EIGHT = 8;
  localparam int PORT_D_LINE_NINE  = 9;
  localparam logic [15:0] PORT_D_PULLUP_RESET = 16'hFFFF;
  localparam logic [15:0] PORT_D_DIR_RESET    = 16'h0000;
  localparam logic [15:0] PORT_D_ALT_RESET    = 16'h0000;
  // ---------------------------------------------------------------
  // access timing (cycles the strobe stays low)
  // ---------------------------------------------------------------
  localparam int STROBE_TIME_NS = 60;
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int STROBE_CYCLES_INT = (STROBE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] STROBE_CYCLES = 4'(STROBE_CYCLES_INT);
  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WRITE = 4'h2,
    ST_READ  = 4'h4,
    ST_DONE  = 4'h8
  } seq_state_e;
endpackage : ext_mem_pkg

// ===== src/strobe_if.sv
interface strobe_if;
  logic       busy;
  logic       write_low;
  logic       read_low;
  logic       read_end;
  logic [3:0] count;
  modport seq (output busy, output write_low, output read_low, output read_end, output count);
  modport use_side (input busy, input write_low, input read_low, input read_end, input count);
endinterface : strobe_if

// ===== src/strobe_seq.sv
module strobe_seq (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic is_write,
  strobe_if.seq     sb
);
  ext_mem_pkg::seq_state_e state_r;
  ext_mem_pkg::seq_state_e state_nxt;
  logic [3:0]              count_r;
  logic [3:0]              count_nxt;
  wire last = (count_r == ext_mem_pkg::STROBE_CYCLES - 4'h1);

  // ---------------------------------------------------------------
  // next state; one strobe at a time, never both
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ext_mem_pkg::ST_IDLE: begin
        count_nxt = 4'h0;
        if (start) state_nxt = is_write ? ext_mem_pkg::ST_WRITE : ext_mem_pkg::ST_READ;
      end
      ext_mem_pkg::ST_WRITE,
      ext_mem_pkg::ST_READ: begin
        count_nxt = count_r + 4'h1;
        if (last) state_nxt = ext_mem_pkg::ST_DONE;
      end
      ext_mem_pkg::ST_DONE: state_nxt = ext_mem_pkg::ST_IDLE;
      default: state_nxt = ext_mem_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ext_mem_pkg::ST_IDLE;
      count_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign sb.busy      = (state_r != ext_mem_pkg::ST_IDLE);
  assign sb.write_low = (state_nxt == ext_mem_pkg::ST_WRITE);
  assign sb.read_low  = (state_nxt == ext_mem_pkg::ST_READ);
  assign sb.read_end  = (state_r == ext_mem_pkg::ST_READ) && last;
  assign sb.count     = count_r;
endmodule : strobe_seq

// ===== src/ext_mem_strobe_select.sv
module ext_mem_strobe_select (
  input  wire logic        clock,
  input  wire logic        arst_n,
  // access request
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_program,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             ack,
  output logic [15:0]      rdata,
  // configuration bits
  input  wire logic        idle_drive_control,
  input  wire logic        ctrl_pullup_disable,
  input  wire logic [15:0] port_d_pullup_register,
  input  wire logic        port_d_alt_eight,
  input  wire logic        port_d_alt_nine,
  input  wire logic        port_d_dir_eight,
  input  wire logic        port_d_dir_nine,
  input  wire logic        port_d_out_eight,
  input  wire logic        port_d_out_nine,
  output logic             port_d_in_eight,
  output logic             port_d_in_nine,
  // pins
  output logic [23:0]      address_bus_pins,
  input  wire logic [15:0] data_bus_in,
  output logic [15:0]      data_bus_out,
  output logic             data_bus_oe,
  output logic             write_strobe_n,
  output logic             write_strobe_oe,
  output logic             write_strobe_pullup,
  output logic             read_strobe_n,
  output logic             read_strobe_oe,
  output logic             read_strobe_pullup,
  input  wire logic        program_mem_select_in,
  output logic             program_mem_select_n,
  output logic             program_mem_select_oe,
  output logic             program_mem_select_pullup,
  input  wire logic        data_mem_select_in,
  output logic             data_mem_select_n,
  output logic             data_mem_select_oe,
  output logic             data_mem_select_pullup
);
  strobe_if sb ();

  logic        busy_nxt;
  logic        is_write_r;
  logic        is_program_r;
  logic [23:0] addr_r;
  logic [15:0] wdata_r;
  logic        ready_r;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  wire start = req && !sb.busy && ready_r;

  strobe_seq u_seq (
    .clock    (clock),
    .arst_n   (arst_n),
    .start    (start),
    .is_write (req_write),
    .sb       (sb)
  );

  // capture the request; held steady for the whole access
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      is_write_r   <= 1'b0;
      is_program_r <= 1'b0;
      addr_r       <= 24'h000000;
      wdata_r      <= 16'h0000;
    end else if (start) begin
      is_write_r   <= req_write;
      is_program_r <= req_program;
      addr_r       <= req_addr;
      wdata_r      <= req_wdata;
    end
  end

  // pins come out of reset undriven for one cycle, then the bus acts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ready_r <= 1'b0;
    else         ready_r <= 1'b1;
  end

  // ---------------------------------------------------------------
  // next pin values
  // ---------------------------------------------------------------
  wire        active_nxt   = sb.write_low || sb.read_low;
  wire        prog_sel_nxt = active_nxt && (start ? req_program : is_program_r);
  wire        data_sel_nxt = active_nxt && !(start ? req_program : is_program_r);
  wire [23:0] addr_nxt     = start ? req_addr : addr_r;
  wire [15:0] wdata_nxt    = start ? req_wdata : wdata_r;
  wire        drive_idle   = idle_drive_control && ready_r;
  assign busy_nxt = active_nxt;

  // ---------------------------------------------------------------
  // strobes, selects and data bus registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      write_strobe_oe <= 1'b0;
      read_strobe_oe  <= 1'b0;
      data_bus_out   <= 16'h0000;
      data_bus_oe    <= 1'b0;
      address_bus_pins <= 24'h000000;
    end else begin
      write_strobe_n  <= !sb.write_low;
      read_strobe_n   <= !sb.read_low;
      write_strobe_oe <= busy_nxt || drive_idle;
      read_strobe_oe  <= busy_nxt || drive_idle;
      data_bus_out    <= wdata_nxt;
      data_bus_oe     <= sb.write_low;
      address_bus_pins <= addr_nxt;
    end
  end

  // select pins double as port d lines when their alt bit is set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      program_mem_select_n  <= 1'b1;
      program_mem_select_oe <= 1'b0;
      data_mem_select_n     <= 1'b1;
      data_mem_select_oe    <= 1'b0;
    end else begin
      program_mem_select_n  <= port_d_alt_eight ? port_d_out_eight : !prog_sel_nxt;
      program_mem_select_oe <= port_d_alt_eight ? port_d_dir_eight
                                                : (busy_nxt || drive_idle);
      data_mem_select_n     <= port_d_alt_nine ? port_d_out_nine : !data_sel_nxt;
      data_mem_select_oe    <= port_d_alt_nine ? port_d_dir_nine
                                               : (busy_nxt || drive_idle);
    end
  end

  // pull-ups: on in reset, then per configuration bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_strobe_pullup       <= 1'b1;
      read_strobe_pullup        <= 1'b1;
      program_mem_select_pullup <= 1'b1;
      data_mem_select_pullup    <= 1'b1;
    end else begin
      write_strobe_pullup       <= !ctrl_pullup_disable;
      read_strobe_pullup        <= !ctrl_pullup_disable;
      program_mem_select_pullup <= port_d_pullup_register[ext_mem_pkg::PORT_D_LINE_EIGHT];
      data_mem_select_pullup    <= port_d_pullup_register[ext_mem_pkg::PORT_D_LINE_NINE];
    end
  end

  // ---------------------------------------------------------------
  // read data capture and completion
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata           <= 16'h0000;
      ack             <= 1'b0;
      port_d_in_eight <= 1'b1;
      port_d_in_nine  <= 1'b1;
    end else begin
      if (sb.read_end) rdata <= data_bus_in;
      ack             <= sb.busy && !active_nxt && !start && (write_strobe_n == 1'b0
                         || read_strobe_n == 1'b0);
      port_d_in_eight <= program_mem_select_in;
      port_d_in_nine  <= data_mem_select_in;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_wr_data;
    @(posedge clock) disable iff (!arst_n)
      !write_strobe_n |-> data_bus_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("data bus not driven in write");

  property p_wr_len;
    @(posedge clock) disable iff (!arst_n)
      $fell(write_strobe_n) |-> (!write_strobe_n)[*3] ##1 write_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");

  // the address is launched on the edge that drops the strobe, then held
  property p_wr_valid;
    @(posedge clock) disable iff (!arst_n)
      !write_strobe_n && !port_d_alt_eight && !port_d_alt_nine
        |-> write_strobe_oe && program_mem_select_oe && data_mem_select_oe
            && (program_mem_select_n != data_mem_select_n)
            && ($fell(write_strobe_n) || $stable(address_bus_pins));
  endproperty
  a_wr_valid: assert property (p_wr_valid) else $error("select or address invalid");

  property p_idle_drive;
    @(posedge clock) disable iff (!arst_n)
      $past(ready_r) && write_strobe_n && read_strobe_n && $past(!busy_nxt)
        |-> write_strobe_oe == $past(idle_drive_control);
  endproperty
  a_idle_drive: assert property (p_idle_drive) else $error("idle drive wrong");

  property p_no_both;
    @(posedge clock) disable iff (!arst_n)
      !(!write_strobe_n && !read_strobe_n) && !(!program_mem_select_n && !data_mem_select_n
        && !port_d_alt_eight && !port_d_alt_nine);
  endproperty
  a_no_both: assert property (p_no_both) else $error("two strobes or selects");

  property p_pullup;
    @(posedge clock) disable iff (!arst_n)
      ##1 write_strobe_pullup == !$past(ctrl_pullup_disable);
  endproperty
  a_pullup: assert property (p_pullup) else $error("strobe pull-up wrong");

  property p_prog_sel;
    @(posedge clock) disable iff (!arst_n)
      start && req_program && !port_d_alt_eight ##1 !port_d_alt_eight |-> !program_mem_select_n;
  endproperty
  a_prog_sel: assert property (p_prog_sel) else $error("program select missing");

  property p_data_sel;
    @(posedge clock) disable iff (!arst_n)
      start && !req_program && !port_d_alt_nine ##1 !port_d_alt_nine |-> !data_mem_select_n;
  endproperty
  a_data_sel: assert property (p_data_sel) else $error("data select missing");

  property p_rd_cap;
    @(posedge clock) disable iff (!arst_n)
      sb.read_end |=> rdata == $past(data_bus_in);
  endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("read data not captured");

  property p_port_pu;
    @(posedge clock) disable iff (!arst_n)
      ##1 data_mem_select_pullup == $past(port_d_pullup_register[ext_mem_pkg::PORT_D_LINE_NINE]);
  endproperty
  a_port_pu: assert property (p_port_pu) else $error("port line pull-up wrong");

  property p_prog_pu;
    @(posedge clock) disable iff (!arst_n)
      ##1 program_mem_select_pullup
          == $past(port_d_pullup_register[ext_mem_pkg::PORT_D_LINE_EIGHT]);
  endproperty
  a_prog_pu: assert property (p_prog_pu) else $error("program pin pull-up wrong");

  // read cycle: bus left to the memory, strobe as long as a write strobe
  property p_rd_bus;
    @(posedge clock) disable iff (!arst_n)
      !read_strobe_n |-> !data_bus_oe;
  endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("data bus driven in read");

  property p_rd_len;
    @(posedge clock) disable iff (!arst_n)
      $fell(read_strobe_n) |-> (!read_strobe_n)[*3] ##1 read_strobe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");

  // idle select drive; oe is registered, so it follows the cycle before
  property p_prog_idle;
    @(posedge clock) disable iff (!arst_n)
      $past(ready_r && !busy_nxt && !port_d_alt_eight)
        |-> program_mem_select_oe == $past(idle_drive_control);
  endproperty
  a_prog_idle: assert property (p_prog_idle) else $error("prog select idle drive wrong");

  property p_data_idle;
    @(posedge clock) disable iff (!arst_n)
      $past(ready_r && !busy_nxt && !port_d_alt_nine)
        |-> data_mem_select_oe == $past(idle_drive_control);
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data select idle drive wrong");

  // alternate use: the pins follow the port d direction and output bits
  property p_line_eight;
    @(posedge clock) disable iff (!arst_n)
      $past(port_d_alt_eight) |-> program_mem_select_oe == $past(port_d_dir_eight)
        && program_mem_select_n == $past(port_d_out_eight);
  endproperty
  a_line_eight: assert property (p_line_eight) else $error("port line eight wrong");

  property p_line_nine;
    @(posedge clock) disable iff (!arst_n)
      $past(port_d_alt_nine) |-> data_mem_select_oe == $past(port_d_dir_nine)
        && data_mem_select_n == $past(port_d_out_nine);
  endproperty
  a_line_nine: assert property (p_line_nine) else $error("port line nine wrong");
endmodule : ext_mem_strobe_select

// ===== test/sram_model.sv
// static memory on the far side of the strobes and selects
module sram_model (
  input  wire logic        clock,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        program_mem_select_n,
  input  wire logic        data_mem_select_n,
  input  wire logic [23:0] address_bus_pins,
  input  wire logic [15:0] data_bus_out,
  output logic      [15:0] data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [24:0]];
  logic [24:0] key_r;
  logic [15:0] wdata_r;
  logic        pend_r = 1'b0;
  logic [15:0] last_r = 16'h5A5A;
  wire  [24:0] key      = {~program_mem_select_n, address_bus_pins};
  wire         selected = !(program_mem_select_n && data_mem_select_n);
  // ---------------------------------------------------------------
  // write capture
  // ---------------------------------------------------------------
  // sampled mid-cycle so the commit never races the strobe edge
  always @(negedge clock) begin
    if (!write_strobe_n && selected) begin
      key_r   <= key;
      wdata_r <= data_bus_out;
      pend_r  <= 1'b1;
    end else if (pend_r && write_strobe_n) begin
      mem[key_r] = wdata_r;
      pend_r <= 1'b0;
    end
    last_r <= data_bus_in;
  end
  // released bus shows the inverse of its last value, never a stale match
  always @* begin
    if (!read_strobe_n && selected)
      data_bus_in = mem.exists(key) ? mem[key] : 16'h0000;
    else
      data_bus_in = ~last_r;
  end
endmodule : sram_model

// ===== test/ext_mem_strobe_select_bench.sv
module ext_mem_strobe_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, req, req_write, req_program, ack, idle_drive_control, ctrl_pullup_disable;
  logic [23:0] req_addr, address_bus_pins;
  logic [15:0] req_wdata, rdata, port_d_pullup_register, data_bus_in, data_bus_out;
  logic port_d_alt_eight, port_d_alt_nine, port_d_dir_eight, port_d_dir_nine;
  logic port_d_out_eight, port_d_out_nine, port_d_in_eight, port_d_in_nine, ext8, ext9;
  logic data_bus_oe, write_strobe_n, write_strobe_oe, write_strobe_pullup;
  logic read_strobe_n, read_strobe_oe, read_strobe_pullup;
  logic program_mem_select_n, program_mem_select_oe, program_mem_select_pullup;
  logic data_mem_select_n, data_mem_select_oe, data_mem_select_pullup;
  logic program_mem_select_in, data_mem_select_in;
  logic [15:0] exp_mem [logic [24:0]];
  int fail_count = 0;
  int comparisons = 0;
  // select pins: the device when enabled, else whatever the board puts there
  assign program_mem_select_in = program_mem_select_oe ? program_mem_select_n : ext8;
  assign data_mem_select_in    = data_mem_select_oe ? data_mem_select_n : ext9;
  ext_mem_strobe_select i_dut (.clock, .arst_n, .req, .req_write, .req_program, .req_addr,
    .req_wdata, .ack, .rdata, .idle_drive_control, .ctrl_pullup_disable, .port_d_pullup_register,
    .port_d_alt_eight, .port_d_alt_nine, .port_d_dir_eight, .port_d_dir_nine, .port_d_out_eight,
    .port_d_out_nine, .port_d_in_eight, .port_d_in_nine, .address_bus_pins, .data_bus_in,
    .data_bus_out, .data_bus_oe, .write_strobe_n, .write_strobe_oe, .write_strobe_pullup,
    .read_strobe_n, .read_strobe_oe, .read_strobe_pullup, .program_mem_select_in,
    .program_mem_select_n, .program_mem_select_oe, .program_mem_select_pullup,
    .data_mem_select_in, .data_mem_select_n, .data_mem_select_oe, .data_mem_select_pullup);
  sram_model i_mem (.clock, .write_strobe_n, .read_strobe_n, .program_mem_select_n,
    .data_mem_select_n, .address_bus_pins, .data_bus_out, .data_bus_in);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [24:0] key_of(input logic p, input logic [23:0] a);
    return {p, a};
  endfunction : key_of
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles
  // one access; request held until its strobe falls, so it is never lost
  task automatic access(input logic w, input logic p, input logic [23:0] a, input logic [15:0] d);
    int n;
    req = 1'b1;
    req_write = w;
    req_program = p;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while ((w ? write_strobe_n : read_strobe_n) !== 1'b0 && n < 8) begin
      cycles(1);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      conclude();
    end
    req = 1'b0;
    check(write_strobe_n, !w);
    check(read_strobe_n, w);
    check(data_bus_oe, w);
    if (w) check(data_bus_out, d);
    check(address_bus_pins, a);
    check(program_mem_select_n, !p);
    check(data_mem_select_n, p);
    check({write_strobe_oe, read_strobe_oe}, 2'h3);
    check({program_mem_select_oe, data_mem_select_oe}, 2'h3);
    n = 0;
    while (ack !== 1'b1 && n < 8) begin
      cycles(1);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      conclude();
    end
    check(write_strobe_n, 1'b1);
    if (!w) check(rdata, exp_mem[key_of(p, a)]);
    cycles(2);
  endtask : access
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    logic [23:0] a;
    logic [15:0] d;
    logic        p;
    {arst_n, req, req_write, req_program, req_addr, req_wdata} = '0;
    {idle_drive_control, ctrl_pullup_disable, port_d_alt_eight, port_d_alt_nine} = '0;
    {port_d_dir_eight, port_d_dir_nine, port_d_out_eight, port_d_out_nine, ext8, ext9} = '0;
    port_d_pullup_register = 16'hFFFF;
    void'($urandom(21));
    cycles(5);
    check({write_strobe_n, program_mem_select_n, data_mem_select_n}, 3'h7);
    check({read_strobe_n, read_strobe_oe, read_strobe_pullup}, 3'h5);
    check({write_strobe_oe, program_mem_select_oe, data_mem_select_oe}, 3'h0);
    check({write_strobe_pullup, program_mem_select_pullup, data_mem_select_pullup}, 3'h7);
    cycles(5);
    arst_n = 1'b1;
    cycles(2);
    check({write_strobe_oe, program_mem_select_oe, data_mem_select_oe}, 3'h0);
    check(read_strobe_oe, 1'b0);
    idle_drive_control = 1'b1; // recommended setting
    cycles(2);
    check({write_strobe_oe, program_mem_select_oe, data_mem_select_oe}, 3'h7);
    check(read_strobe_oe, 1'b1);
    check({write_strobe_n, program_mem_select_n, data_mem_select_n}, 3'h7);
    ctrl_pullup_disable = 1'b1;
    port_d_pullup_register = 16'hFCFF;
    cycles(2);
    check({write_strobe_pullup, read_strobe_pullup}, 2'h0);
    check({program_mem_select_pullup, data_mem_select_pullup}, 2'h0);
    ctrl_pullup_disable = 1'b0;
    port_d_pullup_register = 16'hFFFF;
    cycles(2);
    check({write_strobe_pullup, read_strobe_pullup}, 2'h3);
    // random traffic with both ends of the address range among it
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 24'h000000 : (i == 1) ? 24'hFFFFFF : 24'($urandom);
      p = 1'($urandom_range(0, 1));
      d = 16'($urandom);
      exp_mem[key_of(p, a)] = d;
      access(1'b1, p, a, d);
      access(1'b0, p, a, 16'h0000);
    end
    // idle drive off: pins float between accesses and are driven during them
    idle_drive_control = 1'b0;
    cycles(2);
    check({write_strobe_oe, read_strobe_oe}, 2'h0);
    check({program_mem_select_oe, data_mem_select_oe}, 2'h0);
    exp_mem[key_of(1'b0, 24'h00A5C3)] = 16'h3CC3;
    access(1'b1, 1'b0, 24'h00A5C3, 16'h3CC3);
    access(1'b0, 1'b0, 24'h00A5C3, 16'h0000);
    // select pins as port d lines
    port_d_alt_eight = 1'b1;
    port_d_alt_nine = 1'b1;
    for (int v = 0; v < 2; v++) begin
      {port_d_dir_eight, port_d_dir_nine} = 2'h3;
      {port_d_out_eight, port_d_out_nine} = {1'(v), 1'(!v)};
      cycles(2);
      check({program_mem_select_oe, program_mem_select_n}, {1'b1, 1'(v)});
      check({data_mem_select_oe, data_mem_select_n}, {1'b1, 1'(!v)});
      {port_d_dir_eight, port_d_dir_nine} = 2'h0;
      {ext8, ext9} = {1'(!v), 1'(v)};
      cycles(3);
      check({program_mem_select_oe, port_d_in_eight}, {1'b0, 1'(!v)});
      check({data_mem_select_oe, port_d_in_nine}, {1'b0, 1'(v)});
    end
    conclude();
  end
endmodule : ext_mem_strobe_select_bench
